// File: design/serial_baud_rate_generator.sv
`timescale 1ns/1ps
`include "serial_baud_rate_generator_defines.svh"

// Overview of operation
// - One rate timer, 8-bit or 16-bit, clocks both asynchronous and synchronous modes.
// - Timer is 8-bit after reset; wide-divider select switches it to 16-bit.
// - Timer runs freely; its period comes from the divisor low byte, and also from the high byte when wide divider is selected.
// - Asynchronous multiplier picked from high-speed and wide-divider selects together.
// - Async, narrow divider, low speed: rate is clock over 64 times (n+1).
// - Async, wide divider, low speed: rate is clock over 16 times (n+1).
// - Synchronous mode, either width: rate is clock over 4 times (n+1).
// - Writing either divisor byte clears the rate timer at once.
// - Baud control: overflow 7, idle 6, polarity 4, wide 3, wakeup 1, autobaud 0.
// - Transmit status/control holds synchronous select at 4, high speed at 2.
// - Divisor high byte gives bits 15:8, low byte gives bits 7:0.
// - Unimplemented bits read as zero and ignore writes.

module serial_baud_rate_generator
	import serial_baud_rate_generator_pkg::*;
(
	input  wire logic        CORE_CLK_IN,
	input  wire logic        SYS_RST_IN,
	// AXI4-Lite slave
	input  wire logic [7:0]  S_AXI_AWADDR_IN,
	input  wire logic        S_AXI_AWVALID_IN,
	output logic             S_AXI_AWREADY_OUT,
	input  wire logic [31:0] S_AXI_WDATA_IN,
	input  wire logic [3:0]  S_AXI_WSTRB_IN,
	input  wire logic        S_AXI_WVALID_IN,
	output logic             S_AXI_WREADY_OUT,
	output logic [1:0]       S_AXI_BRESP_OUT,
	output logic             S_AXI_BVALID_OUT,
	input  wire logic        S_AXI_BREADY_IN,
	input  wire logic [7:0]  S_AXI_ARADDR_IN,
	input  wire logic        S_AXI_ARVALID_IN,
	output logic             S_AXI_ARREADY_OUT,
	output logic [31:0]      S_AXI_RDATA_OUT,
	output logic [1:0]       S_AXI_RRESP_OUT,
	output logic             S_AXI_RVALID_OUT,
	input  wire logic        S_AXI_RREADY_IN,
	// Status from the rest of the serial port
	input  wire logic        RX_IDLE_IN,
	input  wire logic        RX_FRAMING_ERROR_IN,
	input  wire logic        RX_OVERRUN_ERROR_IN,
	input  wire logic        TX_SHIFT_EMPTY_IN,
	// Rate outputs and configuration to the rest of the port
	output logic             TIMER_TICK_OUT,
	output logic             BAUD_TICK_OUT,
	output logic [7:0]       BAUD_CONTROL_OUT,
	output logic [7:0]       RECEIVE_STATUS_CONTROL_OUT,
	output logic [7:0]       TRANSMIT_STATUS_CONTROL_OUT
);

	// ----------------------------------------------------------------------
	// Functions
	// ----------------------------------------------------------------------

	// Clocks per baud period after the timer, minus one
	function automatic logic [5:0] mult_m1(input logic sync_mode, input logic wide,
			input logic high_speed);
		logic [5:0] m;
		m = `MULT_DIV4_M1;
		if (sync_mode) begin
			m = `MULT_DIV4_M1;
		end else if (!wide && !high_speed) begin
			m = `MULT_DIV64_M1;
		end else if (wide && !high_speed) begin
			m = `MULT_DIV16_M1;
		end else if (!wide && high_speed) begin
			m = `MULT_DIV16_M1;
		end else begin
			m = `MULT_DIV4_M1;
		end
		return m;
	endfunction

	// Write one byte lane into a register, keeping only implemented bits
	function automatic logic [7:0] merge_byte(input logic [7:0] old_val,
			input logic [7:0] new_val, input logic [7:0] rw_mask);
		return (old_val & ~rw_mask) | (new_val & rw_mask);
	endfunction

	// ----------------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------------

	write_state_type wr_state_q, wr_state_d;
	read_state_type  rd_state_q, rd_state_d;

	logic        aw_held_q, aw_held_d;
	logic [7:0]  aw_addr_q, aw_addr_d;
	logic        w_held_q, w_held_d;
	logic [7:0]  w_data_q, w_data_d;
	logic        w_strb_q, w_strb_d;
	logic [1:0]  bresp_q, bresp_d;
	logic [31:0] rdata_q, rdata_d;
	logic [1:0]  rresp_q, rresp_d;

	logic [7:0]  baud_ctl_q, baud_ctl_d;
	logic [7:0]  rx_ctl_q, rx_ctl_d;
	logic [7:0]  tx_ctl_q, tx_ctl_d;
	logic [7:0]  div_low_q, div_low_d;
	logic [7:0]  div_high_q, div_high_d;

	logic [15:0] timer_q, timer_d;
	logic [5:0]  post_q, post_d;
	logic        timer_tick_q, timer_tick_d;
	logic        baud_tick_q, baud_tick_d;

	logic        aw_take;
	logic        w_take;
	logic        aw_have;
	logic        w_have;
	logic        do_write;
	logic [7:0]  wr_addr;
	logic [7:0]  wr_data;
	logic        wr_lane;
	logic        div_written;
	logic [15:0] period_m1;
	logic [7:0]  baud_ctl_rd;
	logic [7:0]  rx_ctl_rd;
	logic [7:0]  tx_ctl_rd;

	// ----------------------------------------------------------------------
	// Bus handshakes
	// ----------------------------------------------------------------------

	// Address and data accepted in either order, one write in flight
	assign S_AXI_AWREADY_OUT = (wr_state_q == WR_COLLECT) && !aw_held_q;
	assign S_AXI_WREADY_OUT  = (wr_state_q == WR_COLLECT) && !w_held_q;
	assign S_AXI_ARREADY_OUT = (rd_state_q == RD_IDLE);
	assign S_AXI_BVALID_OUT  = (wr_state_q == WR_RESPOND);
	assign S_AXI_RVALID_OUT  = (rd_state_q == RD_RESPOND);
	assign S_AXI_BRESP_OUT   = bresp_q;
	assign S_AXI_RDATA_OUT   = rdata_q;
	assign S_AXI_RRESP_OUT   = rresp_q;

	// Write decode terms
	assign aw_take  = S_AXI_AWVALID_IN && S_AXI_AWREADY_OUT;
	assign w_take   = S_AXI_WVALID_IN && S_AXI_WREADY_OUT;
	assign aw_have  = aw_held_q || aw_take;
	assign w_have   = w_held_q || w_take;
	assign do_write = (wr_state_q == WR_COLLECT) && aw_have && w_have;
	assign wr_addr  = aw_held_q ? aw_addr_q : S_AXI_AWADDR_IN;
	assign wr_data  = w_held_q ? w_data_q : S_AXI_WDATA_IN[7:0];
	assign wr_lane  = w_held_q ? w_strb_q : S_AXI_WSTRB_IN[0];

	// Readback views with live status bits
	assign baud_ctl_rd = {baud_ctl_q[7], RX_IDLE_IN, baud_ctl_q[5:0]};
	assign rx_ctl_rd   = {rx_ctl_q[7:3], RX_FRAMING_ERROR_IN, RX_OVERRUN_ERROR_IN,
		rx_ctl_q[0]};
	assign tx_ctl_rd   = {tx_ctl_q[7:2], TX_SHIFT_EMPTY_IN, tx_ctl_q[0]};

	// ----------------------------------------------------------------------
	// Write channel and register file
	// ----------------------------------------------------------------------

	// Next state of write channel and writable registers
	always_comb begin
		wr_state_d  = wr_state_q;
		aw_held_d   = aw_held_q;
		aw_addr_d   = aw_addr_q;
		w_held_d    = w_held_q;
		w_data_d    = w_data_q;
		w_strb_d    = w_strb_q;
		bresp_d     = bresp_q;
		baud_ctl_d  = baud_ctl_q;
		rx_ctl_d    = rx_ctl_q;
		tx_ctl_d    = tx_ctl_q;
		div_low_d   = div_low_q;
		div_high_d  = div_high_q;
		div_written = 1'b0;
		case (wr_state_q)
			WR_COLLECT: begin
				if (aw_take && !do_write) begin
					aw_held_d = 1'b1;
					aw_addr_d = S_AXI_AWADDR_IN;
				end
				if (w_take && !do_write) begin
					w_held_d = 1'b1;
					w_data_d = S_AXI_WDATA_IN[7:0];
					w_strb_d = S_AXI_WSTRB_IN[0];
				end
				if (do_write) begin
					aw_held_d  = 1'b0;
					w_held_d   = 1'b0;
					bresp_d    = `RESP_OKAY;
					wr_state_d = WR_RESPOND;
					case (wr_addr)
						`OFS_BAUD_CONTROL: begin
							if (wr_lane) begin
								baud_ctl_d = merge_byte(baud_ctl_q, wr_data,
									`MASK_BAUD_CONTROL_RW);
							end
						end
						`OFS_RECEIVE_STATUS_CONTROL: begin
							if (wr_lane) begin
								rx_ctl_d = merge_byte(rx_ctl_q, wr_data, `MASK_RECEIVE_RW);
							end
						end
						`OFS_RATE_DIVISOR_LOW: begin
							if (wr_lane) begin
								div_low_d   = wr_data;
								div_written = 1'b1;
							end
						end
						`OFS_RATE_DIVISOR_HIGH: begin
							if (wr_lane) begin
								div_high_d  = wr_data;
								div_written = 1'b1;
							end
						end
						`OFS_TRANSMIT_STATUS_CONTROL: begin
							if (wr_lane) begin
								tx_ctl_d = merge_byte(tx_ctl_q, wr_data,
									`MASK_TRANSMIT_RW);
							end
						end
						default: begin
							bresp_d = `RESP_SLVERR;
						end
					endcase
				end
			end
			WR_RESPOND: begin
				if (S_AXI_BREADY_IN) begin
					wr_state_d = WR_COLLECT;
				end
			end
			default: begin
				wr_state_d = WR_COLLECT;
			end
		endcase
	end

	// Registers of the write channel
	always_ff @(posedge CORE_CLK_IN or posedge SYS_RST_IN) begin
		if (SYS_RST_IN) begin
			wr_state_q <= WR_COLLECT;
			aw_held_q  <= 1'b0;
			aw_addr_q  <= 8'h00;
			w_held_q   <= 1'b0;
			w_data_q   <= 8'h00;
			w_strb_q   <= 1'b0;
			bresp_q    <= `RESP_OKAY;
			baud_ctl_q <= `RST_BAUD_CONTROL;
			rx_ctl_q   <= `RST_RECEIVE_STATUS_CONTROL;
			tx_ctl_q   <= `RST_TRANSMIT_STATUS_CONTROL;
			div_low_q  <= `RST_RATE_DIVISOR;
			div_high_q <= `RST_RATE_DIVISOR;
		end else begin
			wr_state_q <= wr_state_d;
			aw_held_q  <= aw_held_d;
			aw_addr_q  <= aw_addr_d;
			w_held_q   <= w_held_d;
			w_data_q   <= w_data_d;
			w_strb_q   <= w_strb_d;
			bresp_q    <= bresp_d;
			baud_ctl_q <= baud_ctl_d;
			rx_ctl_q   <= rx_ctl_d;
			tx_ctl_q   <= tx_ctl_d;
			div_low_q  <= div_low_d;
			div_high_q <= div_high_d;
		end
	end

	// ----------------------------------------------------------------------
	// Read channel
	// ----------------------------------------------------------------------

	// Next state of read channel; upper data bits always zero
	always_comb begin
		rd_state_d = rd_state_q;
		rdata_d    = rdata_q;
		rresp_d    = rresp_q;
		case (rd_state_q)
			RD_IDLE: begin
				if (S_AXI_ARVALID_IN) begin
					rd_state_d = RD_RESPOND;
					rresp_d    = `RESP_OKAY;
					rdata_d    = 32'h0000_0000;
					case (S_AXI_ARADDR_IN)
						`OFS_BAUD_CONTROL:            rdata_d[7:0] = baud_ctl_rd;
						`OFS_RECEIVE_STATUS_CONTROL:  rdata_d[7:0] = rx_ctl_rd;
						`OFS_RATE_DIVISOR_LOW:        rdata_d[7:0] = div_low_q;
						`OFS_RATE_DIVISOR_HIGH:       rdata_d[7:0] = div_high_q;
						`OFS_TRANSMIT_STATUS_CONTROL: rdata_d[7:0] = tx_ctl_rd;
						default:                      rresp_d      = `RESP_SLVERR;
					endcase
				end
			end
			RD_RESPOND: begin
				if (S_AXI_RREADY_IN) begin
					rd_state_d = RD_IDLE;
				end
			end
			default: begin
				rd_state_d = RD_IDLE;
			end
		endcase
	end

	// Registers of the read channel
	always_ff @(posedge CORE_CLK_IN or posedge SYS_RST_IN) begin
		if (SYS_RST_IN) begin
			rd_state_q <= RD_IDLE;
			rdata_q    <= 32'h0000_0000;
			rresp_q    <= `RESP_OKAY;
		end else begin
			rd_state_q <= rd_state_d;
			rdata_q    <= rdata_d;
			rresp_q    <= rresp_d;
		end
	end

	// ----------------------------------------------------------------------
	// Rate timer and multiplier
	// ----------------------------------------------------------------------

	// Period source: low byte only unless wide divider selected
	assign period_m1 = baud_ctl_q[`BIT_WIDE_DIVIDER] ? {div_high_q, div_low_q}
		: {8'h00, div_low_q};

	// Free-running timer with post multiplier
	always_comb begin
		timer_d      = timer_q + 16'h0001;
		post_d       = post_q;
		timer_tick_d = 1'b0;
		baud_tick_d  = 1'b0;
		if (div_written) begin
			timer_d = 16'h0000;
			post_d  = 6'h00;
		end else if (timer_q >= period_m1) begin
			timer_d      = 16'h0000;
			timer_tick_d = 1'b1;
			if (post_q >= mult_m1(tx_ctl_q[`BIT_SYNC_MODE], baud_ctl_q[`BIT_WIDE_DIVIDER],
					tx_ctl_q[`BIT_HIGH_SPEED])) begin
				post_d      = 6'h00;
				baud_tick_d = 1'b1;
			end else begin
				post_d = post_q + 6'h01;
			end
		end
	end

	// Registers of the timer
	always_ff @(posedge CORE_CLK_IN or posedge SYS_RST_IN) begin
		if (SYS_RST_IN) begin
			timer_q      <= 16'h0000;
			post_q       <= 6'h00;
			timer_tick_q <= 1'b0;
			baud_tick_q  <= 1'b0;
		end else begin
			timer_q      <= timer_d;
			post_q       <= post_d;
			timer_tick_q <= timer_tick_d;
			baud_tick_q  <= baud_tick_d;
		end
	end

	// ----------------------------------------------------------------------
	// Outputs to the rest of the port
	// ----------------------------------------------------------------------

	// Configuration and ticks, all from flip-flops
	assign TIMER_TICK_OUT              = timer_tick_q;
	assign BAUD_TICK_OUT               = baud_tick_q;
	assign BAUD_CONTROL_OUT            = baud_ctl_q;
	assign RECEIVE_STATUS_CONTROL_OUT  = rx_ctl_q;
	assign TRANSMIT_STATUS_CONTROL_OUT = tx_ctl_q;

endmodule

// File: design/serial_baud_rate_generator_defines.svh
`ifndef SERIAL_BAUD_RATE_GENERATOR_DEFINES_SVH
`define SERIAL_BAUD_RATE_GENERATOR_DEFINES_SVH

// ----------------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------------
`define OFS_BAUD_CONTROL            8'h00
`define OFS_RECEIVE_STATUS_CONTROL  8'h04
`define OFS_RATE_DIVISOR_LOW        8'h08
`define OFS_RATE_DIVISOR_HIGH       8'h0C
`define OFS_TRANSMIT_STATUS_CONTROL 8'h10

// ----------------------------------------------------------------------
// Baud control bit positions
// ----------------------------------------------------------------------
`define BIT_AUTOBAUD_OVERFLOW       7
`define BIT_RECEIVE_IDLE            6
`define BIT_CLOCK_POLARITY          4
`define BIT_WIDE_DIVIDER            3
`define BIT_WAKEUP_ENABLE           1
`define BIT_AUTOBAUD_ENABLE         0
`define MASK_BAUD_CONTROL_RW        8'h9B

// ----------------------------------------------------------------------
// Transmit and receive status/control bit positions
// ----------------------------------------------------------------------
`define BIT_SYNC_MODE               4
`define BIT_HIGH_SPEED              2
`define BIT_TX_SHIFT_EMPTY          1
`define BIT_RX_FRAMING_ERROR        2
`define BIT_RX_OVERRUN_ERROR        1
`define MASK_TRANSMIT_RW            8'hFD
`define MASK_RECEIVE_RW             8'hF9

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define RST_BAUD_CONTROL            8'h00
`define RST_RECEIVE_STATUS_CONTROL  8'h00
`define RST_RATE_DIVISOR            8'h00
`define RST_TRANSMIT_STATUS_CONTROL 8'h00

// ----------------------------------------------------------------------
// Clocks per baud period after the timer, minus one
// ----------------------------------------------------------------------
`define MULT_DIV64_M1               6'h3F
`define MULT_DIV16_M1               6'h0F
`define MULT_DIV4_M1                6'h03

// ----------------------------------------------------------------------
// Bus responses
// ----------------------------------------------------------------------
`define RESP_OKAY                   2'h0
`define RESP_SLVERR                 2'h2

`endif

// File: design/serial_baud_rate_generator_pkg.sv
package serial_baud_rate_generator_pkg;

	// Write channel sequencing
	typedef enum logic [1:0] {
		WR_COLLECT = 2'b01,
		WR_RESPOND = 2'b10
	} write_state_type;

	// Read channel sequencing
	typedef enum logic [1:0] {
		RD_IDLE    = 2'b01,
		RD_RESPOND = 2'b10
	} read_state_type;

endpackage

// File: bench/serial_baud_rate_generator_assertions.sv
`timescale 1ns/1ps
`include "serial_baud_rate_generator_defines.svh"

module serial_baud_rate_generator_checker (
	input wire logic        CORE_CLK_IN,
	input wire logic        SYS_RST_IN,
	input wire logic [7:0]  S_AXI_AWADDR_IN,
	input wire logic        S_AXI_AWVALID_IN,
	input wire logic        S_AXI_AWREADY_OUT,
	input wire logic [31:0] S_AXI_WDATA_IN,
	input wire logic [3:0]  S_AXI_WSTRB_IN,
	input wire logic        S_AXI_WVALID_IN,
	input wire logic        S_AXI_WREADY_OUT,
	input wire logic [1:0]  S_AXI_BRESP_OUT,
	input wire logic        S_AXI_BVALID_OUT,
	input wire logic        S_AXI_BREADY_IN,
	input wire logic [7:0]  S_AXI_ARADDR_IN,
	input wire logic        S_AXI_ARVALID_IN,
	input wire logic        S_AXI_ARREADY_OUT,
	input wire logic [31:0] S_AXI_RDATA_OUT,
	input wire logic [1:0]  S_AXI_RRESP_OUT,
	input wire logic        S_AXI_RVALID_OUT,
	input wire logic        S_AXI_RREADY_IN,
	input wire logic        RX_IDLE_IN,
	input wire logic [7:0]  BAUD_CONTROL_OUT
);
	logic [7:0] wbyte;

	default clocking @(posedge CORE_CLK_IN); endclocking
	default disable iff (SYS_RST_IN);

	// Low write byte for stored-value checks
	assign wbyte = S_AXI_WDATA_IN[7:0];

	function automatic logic mapped(input logic [7:0] a);
		return a inside {`OFS_BAUD_CONTROL, `OFS_RECEIVE_STATUS_CONTROL, `OFS_RATE_DIVISOR_LOW,
			`OFS_RATE_DIVISOR_HIGH, `OFS_TRANSMIT_STATUS_CONTROL};
	endfunction

	// ------------------------------------------------------------------
	// Bus steps
	// ------------------------------------------------------------------
	sequence wr_taken;
		S_AXI_AWVALID_IN && S_AXI_AWREADY_OUT && S_AXI_WVALID_IN && S_AXI_WREADY_OUT;
	endsequence
	sequence rd_taken;
		S_AXI_ARVALID_IN && S_AXI_ARREADY_OUT;
	endsequence

	a_write_answer: assert property (wr_taken |=> S_AXI_BVALID_OUT && !S_AXI_AWREADY_OUT
		&& !S_AXI_WREADY_OUT) else $error("write response missing");
	a_bresp_hold: assert property (S_AXI_BVALID_OUT && !S_AXI_BREADY_IN |=> S_AXI_BVALID_OUT
		&& $stable(S_AXI_BRESP_OUT)) else $error("write response dropped");
	a_read_answer: assert property (rd_taken |=> S_AXI_RVALID_OUT && !S_AXI_ARREADY_OUT)
		else $error("read response missing");
	a_rdata_hold: assert property (S_AXI_RVALID_OUT && !S_AXI_RREADY_IN |=> S_AXI_RVALID_OUT
		&& $stable(S_AXI_RDATA_OUT)) else $error("read data dropped");
	a_wr_unmapped: assert property (wr_taken ##0 !mapped(S_AXI_AWADDR_IN)
		|=> S_AXI_BRESP_OUT == `RESP_SLVERR) else $error("bad write address accepted");
	a_rd_unmapped: assert property (rd_taken ##0 !mapped(S_AXI_ARADDR_IN)
		|=> S_AXI_RRESP_OUT == `RESP_SLVERR && S_AXI_RDATA_OUT == 32'h0)
		else $error("bad read address accepted");
	a_rdata_upper: assert property (S_AXI_RVALID_OUT |-> S_AXI_RDATA_OUT[31:8] == 24'h0)
		else $error("upper read bits set");
	a_ctrl_write: assert property (wr_taken ##0 (S_AXI_AWADDR_IN == `OFS_BAUD_CONTROL
		&& S_AXI_WSTRB_IN[0]) |=> BAUD_CONTROL_OUT == ($past(wbyte) & `MASK_BAUD_CONTROL_RW))
		else $error("baud control stored wrong");
	a_idle_flag: assert property (rd_taken ##0 S_AXI_ARADDR_IN == `OFS_BAUD_CONTROL
		|=> S_AXI_RDATA_OUT[6] == $past(RX_IDLE_IN)) else $error("receive idle wrong");
endmodule

bind serial_baud_rate_generator serial_baud_rate_generator_checker u_chk (
	.CORE_CLK_IN(CORE_CLK_IN), .SYS_RST_IN(SYS_RST_IN), .S_AXI_AWADDR_IN(S_AXI_AWADDR_IN),
	.S_AXI_AWVALID_IN(S_AXI_AWVALID_IN), .S_AXI_AWREADY_OUT(S_AXI_AWREADY_OUT),
	.S_AXI_WDATA_IN(S_AXI_WDATA_IN), .S_AXI_WSTRB_IN(S_AXI_WSTRB_IN),
	.S_AXI_WVALID_IN(S_AXI_WVALID_IN), .S_AXI_WREADY_OUT(S_AXI_WREADY_OUT),
	.S_AXI_BRESP_OUT(S_AXI_BRESP_OUT), .S_AXI_BVALID_OUT(S_AXI_BVALID_OUT),
	.S_AXI_BREADY_IN(S_AXI_BREADY_IN), .S_AXI_ARADDR_IN(S_AXI_ARADDR_IN),
	.S_AXI_ARVALID_IN(S_AXI_ARVALID_IN), .S_AXI_ARREADY_OUT(S_AXI_ARREADY_OUT),
	.S_AXI_RDATA_OUT(S_AXI_RDATA_OUT), .S_AXI_RRESP_OUT(S_AXI_RRESP_OUT),
	.S_AXI_RVALID_OUT(S_AXI_RVALID_OUT), .S_AXI_RREADY_IN(S_AXI_RREADY_IN),
	.RX_IDLE_IN(RX_IDLE_IN), .BAUD_CONTROL_OUT(BAUD_CONTROL_OUT));

// File: bench/testbench.sv
`timescale 1ns/1ps
`include "serial_baud_rate_generator_defines.svh"

module testbench;
	logic        clk = 1'h0, rst = 1'h1;
	logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic [3:0]  wstrb = 4'h0;
	logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
	logic        rx_idle = 1'h0, rx_fe = 1'h0, rx_oe = 1'h0, tx_empty = 1'h0;
	logic        awready, wready, bvalid, arready, rvalid, tt, bt;
	logic [7:0]  bco, rxo, txo;
	logic [1:0]  bresp, rresp;
	logic [31:0] rdata;
	int          err_total = 0, total_checks = 0;
	logic [31:0] tbl [6] = '{32'h40000102, 32'h10010102, 32'h10020004,
		32'h04030004, 32'h04060102, 32'h04050010};

	serial_baud_rate_generator DUT (.CORE_CLK_IN(clk), .SYS_RST_IN(rst),
		.S_AXI_AWADDR_IN(awaddr), .S_AXI_AWVALID_IN(awvalid), .S_AXI_AWREADY_OUT(awready),
		.S_AXI_WDATA_IN(wdata), .S_AXI_WSTRB_IN(wstrb), .S_AXI_WVALID_IN(wvalid),
		.S_AXI_WREADY_OUT(wready), .S_AXI_BRESP_OUT(bresp), .S_AXI_BVALID_OUT(bvalid),
		.S_AXI_BREADY_IN(bready), .S_AXI_ARADDR_IN(araddr), .S_AXI_ARVALID_IN(arvalid),
		.S_AXI_ARREADY_OUT(arready), .S_AXI_RDATA_OUT(rdata), .S_AXI_RRESP_OUT(rresp),
		.S_AXI_RVALID_OUT(rvalid), .S_AXI_RREADY_IN(rready), .RX_IDLE_IN(rx_idle),
		.RX_FRAMING_ERROR_IN(rx_fe), .RX_OVERRUN_ERROR_IN(rx_oe), .TX_SHIFT_EMPTY_IN(tx_empty),
		.TIMER_TICK_OUT(tt), .BAUD_TICK_OUT(bt), .BAUD_CONTROL_OUT(bco),
		.RECEIVE_STATUS_CONTROL_OUT(rxo), .TRANSMIT_STATUS_CONTROL_OUT(txo));

	// Clock of 5 ns
	always #2.5 clk = ~clk;

	// ------------------------------------------------------------------
	// Access and compare tasks
	// ------------------------------------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			err_total++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [3:0] s,
		input logic [1:0] er);
		logic pa, pw;
		pa = 1'h1;
		pw = 1'h1;
		awaddr <= a;
		wdata <= {24'h000000, d};
		wstrb <= s;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		while (pa || pw) begin
			@(posedge clk);
			if (pa && awready) begin
				awvalid <= 1'h0;
				pa = 1'h0;
			end
			if (pw && wready) begin
				wvalid <= 1'h0;
				pw = 1'h0;
			end
		end
		// Response left waiting one cycle
		@(posedge clk);
		bready <= 1'h1;
		do @(posedge clk); while (!bvalid);
		chk(bresp, er);
		bready <= 1'h0;
		@(posedge clk);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
		araddr <= a;
		arvalid <= 1'h1;
		do @(posedge clk); while (!arready);
		arvalid <= 1'h0;
		@(posedge clk);
		rready <= 1'h1;
		do @(posedge clk); while (!rvalid);
		chk(rdata, ed);
		chk(rresp, er);
		rready <= 1'h0;
		@(posedge clk);
	endtask

	// Edges until the chosen tick is seen
	task automatic gap(input bit baud, output int n);
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (!(baud ? bt : tt));
	endtask

	task automatic summarize();
		$display("checks=%0d mismatches=%0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	// Watchdog for a hung handshake
	initial begin
		repeat (40000) @(posedge clk);
		err_total++;
		summarize();
	end

	// ------------------------------------------------------------------
	// Test sequence
	// ------------------------------------------------------------------
	initial begin
		logic [31:0] e;
		int n, p;
		repeat (5) @(posedge clk);
		rst <= 1'h0;
		@(posedge clk);
		for (int a = 0; a <= 16; a += 4) rd(a[7:0], 32'h0, `RESP_OKAY);
		rd(8'h14, 32'h0, `RESP_SLVERR);
		wr(8'h1C, 8'hFF, 4'h1, `RESP_SLVERR);
		$display("test reset values done");
		rx_idle <= 1'h1;
		rx_fe <= 1'h1;
		tx_empty <= 1'h1;
		wr(`OFS_BAUD_CONTROL, 8'hFF, 4'h1, `RESP_OKAY);
		// Receive idle seen high before any clock change would be allowed
		rd(`OFS_BAUD_CONTROL, 32'hDB, `RESP_OKAY);
		wr(`OFS_BAUD_CONTROL, 8'h00, 4'h0, `RESP_OKAY);
		rd(`OFS_BAUD_CONTROL, 32'hDB, `RESP_OKAY);
		wr(`OFS_TRANSMIT_STATUS_CONTROL, 8'hFF, 4'h1, `RESP_OKAY);
		rd(`OFS_TRANSMIT_STATUS_CONTROL, 32'hFF, `RESP_OKAY);
		wr(`OFS_RECEIVE_STATUS_CONTROL, 8'hFF, 4'h1, `RESP_OKAY);
		rd(`OFS_RECEIVE_STATUS_CONTROL, 32'hFD, `RESP_OKAY);
		// Stored configuration outputs carry no live status bits
		chk({24'h000000, bco}, 32'h9B);
		chk({24'h000000, txo}, 32'hFD);
		chk({24'h000000, rxo}, 32'hF9);
		rx_idle <= 1'h0;
		rx_fe <= 1'h0;
		rx_oe <= 1'h1;
		tx_empty <= 1'h0;
		rd(`OFS_BAUD_CONTROL, 32'h9B, `RESP_OKAY);
		rd(`OFS_TRANSMIT_STATUS_CONTROL, 32'hFD, `RESP_OKAY);
		rd(`OFS_RECEIVE_STATUS_CONTROL, 32'hFB, `RESP_OKAY);
		wr(`OFS_RATE_DIVISOR_HIGH, 8'hA5, 4'h1, `RESP_OKAY);
		wr(`OFS_RATE_DIVISOR_LOW, 8'h5A, 4'h1, `RESP_OKAY);
		rd(`OFS_RATE_DIVISOR_HIGH, 32'hA5, `RESP_OKAY);
		rd(`OFS_RATE_DIVISOR_LOW, 32'h5A, `RESP_OKAY);
		wr(`OFS_RECEIVE_STATUS_CONTROL, 8'h00, 4'h1, `RESP_OKAY);
		$display("test register fields done");
		// Mode table: multiplier, sync/high-speed/wide, high byte, low byte
		for (int k = 0; k < 6; k++) begin
			e = tbl[k];
			wr(`OFS_TRANSMIT_STATUS_CONTROL, {3'h0, e[18], 1'h0, e[17], 2'h0}, 4'h1, `RESP_OKAY);
			wr(`OFS_BAUD_CONTROL, {4'h0, e[16], 3'h0}, 4'h1, `RESP_OKAY);
			wr(`OFS_RATE_DIVISOR_HIGH, e[15:8], 4'h1, `RESP_OKAY);
			wr(`OFS_RATE_DIVISOR_LOW, e[7:0], 4'h1, `RESP_OKAY);
			p = e[16] ? int'(e[15:0]) + 1 : int'(e[7:0]) + 1;
			gap(1'b0, n);
			gap(1'b0, n);
			chk(n, p);
			gap(1'b1, n);
			gap(1'b1, n);
			chk(n, p * int'(e[31:24]));
		end
		$display("test rate modes done");
		wr(`OFS_TRANSMIT_STATUS_CONTROL, 8'h00, 4'h1, `RESP_OKAY);
		wr(`OFS_BAUD_CONTROL, 8'h00, 4'h1, `RESP_OKAY);
		wr(`OFS_RATE_DIVISOR_HIGH, 8'h00, 4'h1, `RESP_OKAY);
		wr(`OFS_RATE_DIVISOR_LOW, 8'h64, 4'h1, `RESP_OKAY);
		// Mid-count rewrite of each divisor byte restarts the period
		for (int k = 0; k < 2; k++) begin
			gap(1'b0, n);
			repeat (50) @(posedge clk);
			wr(k ? `OFS_RATE_DIVISOR_HIGH : `OFS_RATE_DIVISOR_LOW, k ? 8'h00 : 8'h64, 4'h1,
				`RESP_OKAY);
			gap(1'b0, n);
			chk(n, 32'h63);
		end
		$display("test divisor restart done");
		summarize();
	end
endmodule
